// ### hdl/saw_pkg.sv
// saw_pkg: register map, field positions, reset values and value limits
// of the scaled analog watchdog and its amplifier.
// assumes a 32-bit apb register bus with byte addresses.
package saw_pkg;
	// register byte offsets
	localparam logic [7:0] SAW_CTRL = 8'h00;
	localparam logic [7:0] SAW_GAIN = 8'h04;
	localparam logic [7:0] SAW_OFFSET = 8'h08;
	localparam logic [7:0] SAW_UPPER = 8'h0C;
	localparam logic [7:0] SAW_LOWER = 8'h10;
	localparam logic [7:0] SAW_SRCSEL = 8'h14;
	localparam logic [7:0] SAW_DECIMALS = 8'h18;
	localparam logic [7:0] SAW_STATUS = 8'h1C;
	localparam logic [7:0] SAW_LIVE = 8'h20;
	localparam logic [7:0] SAW_REF = 8'h24;
	localparam logic [7:0] SAW_AMPVAL = 8'h28;
	localparam logic [7:0] SAW_IRQ_STATUS = 8'h2C;
	localparam logic [7:0] SAW_IRQ_MASK = 8'h30;
	localparam logic [7:0] SAW_AMP_GAIN = 8'h34;
	localparam logic [7:0] SAW_AMP_OFFSET = 8'h38;

	// control field positions
	localparam int SAW_CTRL_RETAIN = 0;
	localparam int SAW_CTRL_UP_BLK = 1;
	localparam int SAW_CTRL_LO_BLK = 2;
	// interrupt status bits
	localparam int SAW_EV_SET = 0;
	localparam int SAW_EV_CLR = 1;
	localparam int SAW_EV_CAP = 2;

	// reset values: unity gain (hundredths), zero offset and margins
	localparam logic signed [10:0] SAW_GAIN_RST = 11'sh064;
	localparam logic signed [14:0] SAW_OFFSET_RST = 15'sh0000;
	localparam logic [14:0] SAW_MARGIN_RST = 15'h0000;
	localparam logic [2:0] SAW_CTRL_RST = 3'h0;

	// value limits
	localparam logic signed [31:0] SAW_GAIN_SCALE = 32'sh00000064;
	localparam logic signed [31:0] SAW_GAIN_MAX = 32'sh000003E8;
	localparam logic signed [31:0] SAW_OFFSET_MAX = 32'sh00002710;
	localparam logic signed [31:0] SAW_MARGIN_MAX = 32'sh00004E20;
	localparam logic signed [31:0] SAW_AMP_MAX = 32'sh00007FFF;
	localparam int SAW_RST_STAGES = 2;
endpackage : saw_pkg

// ### hdl/saw_scale_if.sv
// saw_scale_if: one gain/offset scaling request and its result.
// assumes the user side holds raw, gain and offset steady per cycle.
`timescale 1ns/1ps
interface saw_scale_if;
	logic signed [15:0] raw; // value to scale
	logic signed [10:0] gain; // gain in hundredths
	logic signed [14:0] offset; // added after the product
	logic signed [31:0] scaled; // result
	modport user (output raw, output gain, output offset, input scaled);
	modport unit (input raw, input gain, input offset, output scaled);
endinterface : saw_scale_if

// ### hdl/saw_scaler.sv
// saw_scaler: combinational (raw * gain / 100) + offset.
// assumes gain and offset already held inside their legal spans.
`timescale 1ns/1ps
module saw_scaler import saw_pkg::*; #(
	parameter bit SATURATE = 1'b0
) (
	saw_scale_if.unit s // scaling request and result
);
	logic signed [31:0] prod;
	logic signed [31:0] quot;
	logic signed [31:0] sum;

	// gain first, offset after; division truncates toward zero
	assign prod = 32'(s.raw) * 32'(s.gain);
	assign quot = prod / SAW_GAIN_SCALE;
	assign sum = quot + 32'(s.offset);
	// amplifier word is held to its signed span, watchdog path stays wide
	assign s.scaled = !SATURATE ? sum :
		(sum > SAW_AMP_MAX) ? SAW_AMP_MAX :
		(sum < -SAW_AMP_MAX) ? -SAW_AMP_MAX : sum;
endmodule : saw_scaler

// ### hdl/saw_window.sv
// saw_window: window test of the live value around the reference.
// assumes margins are already non-negative and clamped.
`timescale 1ns/1ps
module saw_window (
	input wire logic signed [31:0] live, // scaled live value
	input wire logic signed [31:0] refv, // captured reference
	input wire logic signed [31:0] upper, // upper margin
	input wire logic signed [31:0] lower, // lower margin
	input wire logic enable, // enable level
	input wire logic capture, // rising enable this cycle
	output logic next_flag // flag value for next cycle
);
	logic signed [32:0] lo_bound;
	logic signed [32:0] hi_bound;
	logic outside;

	// 33 bits so the bounds never wrap; bounds themselves count as inside
	assign lo_bound = 33'(refv) - 33'(lower);
	assign hi_bound = 33'(refv) + 33'(upper);
	assign outside = (33'(live) < lo_bound) || (33'(live) > hi_bound);
	// in the capture cycle live equals the new reference, so inside
	assign next_flag = enable && !capture && outside;
endmodule : saw_window

// ### hdl/saw_top.sv
// saw_top: scaled analog watchdog plus analog amplifier, apb registers.
// assumes inputs synchronous to ref_clk; one evaluation per clock cycle.
//
// Functional notes
// - rising enable stores the current scaled monitored value as reference
// - live and reference values are raw times gain, then plus offset
// - flag set while enabled and live value outside reference window
// - flag clears when value returns inside window or enable falls
// - gain is signed hundredths, limited to -10.00 .. 10.00
// - offset signed integer -10000 .. 10000, added after multiplying
// - decimals setting 0..3 is display only, never alters values (register keeps any 0..15)
// - amplifier scales its input and presents result continuously
// - amplifier output word held within -32767 .. 32767
// - margins may come from another selected block's live value
// - margins accept integers 0 .. 20000
// - retentive option keeps watchdog state over power restore
`timescale 1ns/1ps
module saw_top import saw_pkg::*; #(
	parameter int NUM_BLOCKS = 16
) (
	input wire logic ref_clk, // 40 mhz program clock
	input wire logic rst_n, // async power-on reset, active low
	input wire logic [7:0] paddr, // apb byte address
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic watch_enable, // watchdog enable level
	input wire logic signed [15:0] monitored_input, // raw monitored value
	input wire logic signed [15:0] amp_input, // raw amplifier input
	input wire logic [NUM_BLOCKS*16-1:0] block_values, // other blocks' live values
	input wire logic power_restore, // one-cycle pulse after power returns
	output logic watch_flag, // watchdog output flag
	output logic signed [15:0] scaled_output, // amplifier result word
	output logic irq // level interrupt
);
	// reset release through two flops
	logic [SAW_RST_STAGES-1:0] rst_pipe;
	logic rst_sync_n;

	// software registers
	logic [2:0] ctrl;
	logic signed [10:0] gain;
	logic signed [14:0] offset;
	logic [14:0] upper_margin;
	logic [14:0] lower_margin;
	logic [7:0] srcsel;
	logic [3:0] decimals;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic signed [10:0] amp_gain;
	logic signed [14:0] amp_offset;

	// watchdog state
	logic en_prev;
	logic signed [31:0] reference;

	// bus decode
	logic setup;
	logic wr_en;
	logic addr_hit;
	logic [31:0] rd_mux;
	logic wr_ctrl;
	logic wr_gain;
	logic wr_offset;
	logic wr_upper;
	logic wr_lower;
	logic wr_srcsel;
	logic wr_decimals;
	logic wr_irq_clr;
	logic wr_irq_mask;
	logic wr_amp_gain;
	logic wr_amp_offset;
	logic signed [10:0] next_gain;
	logic signed [14:0] next_offset;
	logic [14:0] next_margin;

	// datapath
	logic capture;
	logic signed [31:0] live;
	logic signed [31:0] upper_eff;
	logic signed [31:0] lower_eff;
	logic next_flag;
	logic flag_rise;
	logic flag_fall;
	logic [2:0] events;
	logic restore_clear;
	logic signed [15:0] blk [NUM_BLOCKS];

	saw_scale_if wd_if ();
	saw_scale_if amp_if ();

	// clamp a signed value into lo..hi
	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		clamp = (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction : clamp

	// pick another block's value, zero for an index beyond the table
	function automatic logic signed [15:0] pick(input logic [3:0] idx,
		input logic signed [15:0] tbl [NUM_BLOCKS]);
		pick = (32'(idx) < NUM_BLOCKS) ? tbl[idx] : 16'sh0000;
	endfunction : pick

	// one register address match, shared by every write strobe
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// reset synchroniser; only the last stage is used downstream
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe <= '0;
		end else begin
			rst_pipe <= {rst_pipe[SAW_RST_STAGES-2:0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe[SAW_RST_STAGES-1];

	// unpack the flat block value bus
	generate
		for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_blk
			assign blk[i] = block_values[i*16 +: 16];
		end
	endgenerate

	// apb decode: ready one cycle after setup, so one access cycle
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite && addr_hit;
	assign addr_hit = (paddr[1:0] == 2'h0) && (paddr <= SAW_AMP_OFFSET);

	// read selection; the decimals field is readable but feeds no math
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (paddr)
			SAW_CTRL: rd_mux = {29'h00000000, ctrl};
			SAW_GAIN: rd_mux = 32'(gain);
			SAW_OFFSET: rd_mux = 32'(offset);
			SAW_UPPER: rd_mux = {17'h00000, upper_margin};
			SAW_LOWER: rd_mux = {17'h00000, lower_margin};
			SAW_SRCSEL: rd_mux = {24'h000000, srcsel};
			SAW_DECIMALS: rd_mux = {28'h0000000, decimals};
			SAW_STATUS: rd_mux = {30'h00000000, en_prev, watch_flag};
			SAW_LIVE: rd_mux = live;
			SAW_REF: rd_mux = reference;
			SAW_AMPVAL: rd_mux = 32'(scaled_output);
			SAW_IRQ_STATUS: rd_mux = {29'h00000000, irq_status};
			SAW_IRQ_MASK: rd_mux = {29'h00000000, irq_mask};
			SAW_AMP_GAIN: rd_mux = 32'(amp_gain);
			SAW_AMP_OFFSET: rd_mux = 32'(amp_offset);
			default: rd_mux = 32'h00000000;
		endcase
	end

	// apb answer flops
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !addr_hit;
			if (setup) begin
				prdata <= (!pwrite && addr_hit) ? rd_mux : 32'h00000000;
			end
		end
	end

	// write strobes, one per writable register
	assign wr_ctrl = wr_en && hit(paddr, SAW_CTRL);
	assign wr_gain = wr_en && hit(paddr, SAW_GAIN);
	assign wr_offset = wr_en && hit(paddr, SAW_OFFSET);
	assign wr_upper = wr_en && hit(paddr, SAW_UPPER);
	assign wr_lower = wr_en && hit(paddr, SAW_LOWER);
	assign wr_srcsel = wr_en && hit(paddr, SAW_SRCSEL);
	assign wr_decimals = wr_en && hit(paddr, SAW_DECIMALS);
	assign wr_irq_clr = wr_en && hit(paddr, SAW_IRQ_STATUS);
	assign wr_irq_mask = wr_en && hit(paddr, SAW_IRQ_MASK);
	assign wr_amp_gain = wr_en && hit(paddr, SAW_AMP_GAIN);
	assign wr_amp_offset = wr_en && hit(paddr, SAW_AMP_OFFSET);

	// out-of-range entries saturate instead of faulting, so software sees no error
	assign next_gain = 11'(clamp(signed'(pwdata), -SAW_GAIN_MAX, SAW_GAIN_MAX));
	assign next_offset = 15'(clamp(signed'(pwdata), -SAW_OFFSET_MAX, SAW_OFFSET_MAX));
	assign next_margin = 15'(clamp(signed'(pwdata), 32'sh00000000, SAW_MARGIN_MAX));

	// watchdog configuration
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl <= SAW_CTRL_RST;
			gain <= SAW_GAIN_RST;
			offset <= SAW_OFFSET_RST;
			upper_margin <= SAW_MARGIN_RST;
			lower_margin <= SAW_MARGIN_RST;
			srcsel <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl <= pwdata[2:0];
			end
			if (wr_gain) begin
				gain <= next_gain;
			end
			if (wr_offset) begin
				offset <= next_offset;
			end
			if (wr_upper) begin
				upper_margin <= next_margin;
			end
			if (wr_lower) begin
				lower_margin <= next_margin;
			end
			if (wr_srcsel) begin
				srcsel <= pwdata[7:0];
			end
		end
	end

	// display setting and interrupt mask; decimals never reach the math
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			decimals <= 4'h0;
			irq_mask <= 3'h0;
		end else begin
			if (wr_decimals) begin
				decimals <= pwdata[3:0];
			end
			if (wr_irq_mask) begin
				irq_mask <= pwdata[2:0];
			end
		end
	end

	// amplifier configuration, clamped like the watchdog pair
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			amp_gain <= SAW_GAIN_RST;
			amp_offset <= SAW_OFFSET_RST;
		end else begin
			if (wr_amp_gain) begin
				amp_gain <= next_gain;
			end
			if (wr_amp_offset) begin
				amp_offset <= next_offset;
			end
		end
	end

	// watchdog scaling of the live monitored value
	assign wd_if.raw = monitored_input;
	assign wd_if.gain = gain;
	assign wd_if.offset = offset;
	assign live = wd_if.scaled;

	saw_scaler #(
		.SATURATE(1'b0)
	) u_wd_scale (
		.s(wd_if.unit)
	);

	// amplifier path, saturated to its output word span
	assign amp_if.raw = amp_input;
	assign amp_if.gain = amp_gain;
	assign amp_if.offset = amp_offset;

	saw_scaler #(
		.SATURATE(1'b1)
	) u_amp_scale (
		.s(amp_if.unit)
	);

	// margins either fixed or taken live from another block, clamped alike
	assign upper_eff = ctrl[SAW_CTRL_UP_BLK] ?
		clamp(32'(pick(srcsel[3:0], blk)), 32'sh00000000, SAW_MARGIN_MAX) :
		32'(upper_margin);
	assign lower_eff = ctrl[SAW_CTRL_LO_BLK] ?
		clamp(32'(pick(srcsel[7:4], blk)), 32'sh00000000, SAW_MARGIN_MAX) :
		32'(lower_margin);

	// edge of the enable level; restore wipes state unless retentive
	assign capture = watch_enable && !en_prev;
	assign restore_clear = power_restore && !ctrl[SAW_CTRL_RETAIN];

	saw_window u_window (
		.live(live),
		.refv(reference),
		.upper(upper_eff),
		.lower(lower_eff),
		.enable(watch_enable),
		.capture(capture),
		.next_flag(next_flag)
	);

	// watchdog state, re-evaluated every clock
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			en_prev <= 1'b0;
			reference <= 32'sh00000000;
			watch_flag <= 1'b0;
		end else if (restore_clear) begin
			en_prev <= 1'b0;
			reference <= 32'sh00000000;
			watch_flag <= 1'b0;
		end else begin
			en_prev <= watch_enable;
			if (capture) begin
				reference <= live;
			end
			watch_flag <= next_flag;
		end
	end

	// amplifier word registered so the output comes from a flop
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			scaled_output <= 16'sh0000;
		end else begin
			scaled_output <= amp_if.scaled[15:0];
		end
	end

	// interrupt events: flag set, flag cleared, reference captured
	assign flag_rise = next_flag && !watch_flag && !restore_clear;
	assign flag_fall = !next_flag && watch_flag && !restore_clear;
	assign events = {capture && !restore_clear, flag_fall, flag_rise};

	// sticky status, write one clears; a new event wins over the clear
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= (irq_status & ~(wr_irq_clr ? pwdata[2:0] : 3'h0)) | events;
		end
	end

	// one level interrupt, lags the status by one cycle
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end
endmodule : saw_top

// ### bench/saw_sensor_model.sv
// saw_sensor_model: analog channels feeding the watchdog and a real output stage
// assumes the bench sets the next readings just after a rising edge
`timescale 1ns/1ps
module saw_sensor_model (
	input wire logic ref_clk, // program clock
	input wire logic signed [15:0] set_mon, // next monitored reading
	input wire logic signed [15:0] set_amp, // next amplifier reading
	input wire logic signed [15:0] set_blk, // live value of block 1
	input wire logic signed [15:0] scaled_output, // amplifier word
	output logic signed [15:0] monitored_input, // channel value
	output logic signed [15:0] amp_input, // channel value
	output logic [255:0] block_values, // other blocks' values
	output logic [9:0] level // real output level
);
	// channels refresh once per program cycle, like a converter
	always_ff @(posedge ref_clk) begin
		monitored_input <= set_mon;
		amp_input <= set_amp;
		block_values <= {{14{16'h0123}}, set_blk, 16'h0010};
		level <= 10'((int'(scaled_output) + 32767) * 1000 / 65534);
	end
endmodule : saw_sensor_model

// ### bench/saw_sva.sv
// saw_sva: port checks of flag, amplifier word and apb handshake
// assumes the single ref_clk domain and rst_n of the top module
`timescale 1ns/1ps
module saw_sva (
	input wire logic ref_clk, // program clock
	input wire logic rst_n, // reset, active low
	input wire logic [7:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pready, // apb ready
	input wire logic pslverr, // apb error
	input wire logic watch_enable, // enable level
	input wire logic watch_flag, // watchdog flag
	input wire logic signed [15:0] scaled_output, // amplifier word
	input wire logic irq // interrupt
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// flag follows enable and capture, one cycle late
	AST_FLAG_NEEDS_EN: assert property (watch_flag |-> $past(watch_enable)) else $error("flag without enable");
	AST_EN_LOW_CLEARS: assert property (!watch_enable |=> !watch_flag) else $error("flag after enable low");
	AST_CAPTURE_QUIET: assert property ($rose(watch_enable) |=> !watch_flag) else $error("flag at capture");
	// amplifier word never reaches the most negative code
	AST_AMP_SPAN: assert property (scaled_output != 16'sh8000) else $error("amplifier word out of span");
	// apb answer: one access cycle, error only with ready
	AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready) else $error("ready late");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("error without ready");
	AST_BAD_ADDR: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > 8'h38) |=> pslverr)
		else $error("bad address accepted");
	COV_FLAG: cover property ($rose(watch_flag));
	COV_ERR: cover property (pslverr);
	COV_IRQ: cover property ($rose(irq));
endmodule : saw_sva
bind saw_top saw_sva u_saw_sva (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .watch_enable(watch_enable), .watch_flag(watch_flag),
	.scaled_output(scaled_output), .irq(irq));

// ### bench/testbench.sv
// testbench: drives the watchdog through apb and the sensor model, judges ports and registers
// assumes the saw_pkg register map and a 40 mhz ref_clk
`timescale 1ns/1ps
module testbench import saw_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, watch_enable = 1'b0, power_restore = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, watch_flag, irq, err;
	logic signed [15:0] monitored_input, amp_input, scaled_output;
	logic signed [15:0] set_mon = 16'h0, set_amp = 16'h0, set_blk = 16'h0;
	logic [255:0] block_values;
	logic [9:0] level;
	int miscompares = 0, compares = 0;
	saw_top u_saw_top (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.watch_enable(watch_enable), .monitored_input(monitored_input), .amp_input(amp_input),
		.block_values(block_values), .power_restore(power_restore), .watch_flag(watch_flag),
		.scaled_output(scaled_output), .irq(irq));
	saw_sensor_model u_saw_sensor_model (.ref_clk(ref_clk), .set_mon(set_mon), .set_amp(set_amp),
		.set_blk(set_blk), .scaled_output(scaled_output), .monitored_input(monitored_input),
		.amp_input(amp_input), .block_values(block_values), .level(level));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// four-state compare and tally
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// apb master: answer taken at the rising edge that sees pready, released only then
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask : rdc
	// new reading passes the sensor and flag registers before judging
	task automatic mon(input logic signed [15:0] v, input logic f);
		set_mon <= v;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'(watch_flag), 32'(f));
		@(posedge ref_clk);
	endtask : mon
	task automatic amp(input logic signed [15:0] v, input logic signed [15:0] e);
		set_amp <= v;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		chk(32'(scaled_output), 32'(e));
		@(posedge ref_clk);
	endtask : amp
	// one settled look at the interrupt line, away from the edge that launches it
	task automatic pin(input logic e);
		@(negedge ref_clk);
		chk(32'(irq), 32'(e));
		@(posedge ref_clk);
	endtask : pin
	task automatic t_regs();
		rdc(SAW_GAIN, 32'h00000064);
		apb(SAW_GAIN, 1'b1, 32'h000007D0);
		rdc(SAW_GAIN, 32'h000003E8);
		apb(SAW_GAIN, 1'b1, 32'hFFFFF830);
		rdc(SAW_GAIN, 32'hFFFFFC18);
		apb(SAW_OFFSET, 1'b1, 32'h00004E20);
		rdc(SAW_OFFSET, 32'h00002710);
		apb(SAW_UPPER, 1'b1, 32'h00007530);
		rdc(SAW_UPPER, 32'h00004E20);
		rdc(8'h3C, 32'h0);
		chk(32'(err), 32'h1);
		$display("test regs done");
	endtask : t_regs
	// live 2.00*x-50, window 150-20 .. 150+10, both bounds inclusive
	task automatic t_window();
		apb(SAW_GAIN, 1'b1, 32'h000000C8);
		apb(SAW_OFFSET, 1'b1, 32'hFFFFFFCE);
		apb(SAW_UPPER, 1'b1, 32'h0000000A);
		apb(SAW_LOWER, 1'b1, 32'h00000014);
		mon(16'sd100, 1'b0);
		watch_enable <= 1'b1;
		// the capture edge must pass before the reference is read
		@(posedge ref_clk);
		rdc(SAW_REF, 32'h00000096);
		mon(16'sd105, 1'b0);
		mon(16'sd106, 1'b1);
		mon(16'sd100, 1'b0);
		mon(16'sd90, 1'b0);
		mon(16'sd89, 1'b1);
		apb(SAW_DECIMALS, 1'b1, 32'h0000000F);
		rdc(SAW_LIVE, 32'h00000080);
		mon(16'sd89, 1'b1);
		watch_enable <= 1'b0;
		mon(16'sd89, 1'b0);
		$display("test window done");
	endtask : t_window
	// upper margin of 5 taken from block 1; reference 128
	task automatic t_block();
		apb(SAW_CTRL, 1'b1, 32'h00000002);
		apb(SAW_SRCSEL, 1'b1, 32'h00000001);
		set_blk <= 16'sd5;
		watch_enable <= 1'b1;
		mon(16'sd91, 1'b0);
		mon(16'sd92, 1'b1);
		// lower margin 16 from block 0 too: window 112 .. 133
		apb(SAW_CTRL, 1'b1, 32'h00000006);
		mon(16'sd81, 1'b0);
		mon(16'sd80, 1'b1);
		apb(SAW_CTRL, 1'b1, 32'h00000000);
		mon(16'sd92, 1'b0);
		$display("test block done");
	endtask : t_block
	task automatic t_irq();
		apb(SAW_IRQ_STATUS, 1'b1, 32'h00000007);
		apb(SAW_IRQ_MASK, 1'b1, 32'h00000000);
		mon(16'sd95, 1'b1);
		pin(1'b0);
		rdc(SAW_IRQ_STATUS, 32'h00000001);
		apb(SAW_IRQ_MASK, 1'b1, 32'h00000001);
		pin(1'b1);
		apb(SAW_IRQ_STATUS, 1'b1, 32'h00000001);
		pin(1'b0);
		$display("test irq done");
	endtask : t_irq
	// restore pulse: cleared and recaptured at live 140, or kept when retained
	task automatic t_retain();
		power_restore <= 1'b1;
		@(posedge ref_clk);
		power_restore <= 1'b0;
		mon(16'sd95, 1'b0);
		rdc(SAW_REF, 32'h0000008C);
		mon(16'sd80, 1'b1);
		apb(SAW_CTRL, 1'b1, 32'h00000001);
		power_restore <= 1'b1;
		@(posedge ref_clk);
		power_restore <= 1'b0;
		mon(16'sd80, 1'b1);
		rdc(SAW_REF, 32'h0000008C);
		$display("test retain done");
	endtask : t_retain
	// saturation at both ends, then truncating -2.50 gain
	task automatic t_amp();
		apb(SAW_AMP_GAIN, 1'b1, 32'h000003E8);
		apb(SAW_AMP_OFFSET, 1'b1, 32'h00002710);
		amp(16'sd3000, 16'sd32767);
		chk(32'(level), 32'h000003E8);
		apb(SAW_AMP_OFFSET, 1'b1, 32'hFFFFD8F0);
		amp(-16'sd3000, -16'sd32767);
		chk(32'(level), 32'h00000000);
		apb(SAW_AMP_GAIN, 1'b1, 32'hFFFFFF06);
		apb(SAW_AMP_OFFSET, 1'b1, 32'h00000007);
		amp(16'sd123, -16'sd300);
		rdc(SAW_AMPVAL, 32'hFFFFFED4);
		$display("test amp done");
	endtask : t_amp
	task automatic conclude();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// reset, then the scenarios in order
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		t_regs();
		t_window();
		t_block();
		t_irq();
		t_retain();
		t_amp();
		conclude();
	end
	// the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		conclude();
	end
endmodule : testbench
